/* common/epil_cfg.svh */
// Constants for the external pin interrupt latch: addresses, bit positions, reset values
`ifndef EPIL_CFG_SVH
`define EPIL_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define EPIL_ADDR_W          8
`define EPIL_ADDR_EXT_INT_STATUS_CTRL_REG       8'h00
`define EPIL_ADDR_INT_STAT   8'h04
`define EPIL_ADDR_INT_MASK   8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define EPIL_EXT_INT_STATUS_CTRL_REG_MODE       0
`define EPIL_EXT_INT_STATUS_CTRL_REG_MASK       1
`define EPIL_EXT_INT_STATUS_CTRL_REG_ACK        2
`define EPIL_EXT_INT_STATUS_CTRL_REG_FLAG       3
`define EPIL_EXT_INT_STATUS_CTRL_REG_PIN        4
`define EPIL_EV_SET          0
`define EPIL_EV_CLR          1
`define EPIL_EV_W            2

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define EPIL_PIN_IDLE        1'h1
`define EPIL_MODE_RST        1'h0
`define EPIL_MASK_RST        1'h0
`define EPIL_EV_RST          2'h0
`define EPIL_WORD_ZERO       32'h0000_0000
`define EPIL_RESP_OKAY       2'h0
`define EPIL_RESP_SLVERR     2'h2

`endif

/* common/epil_pkg.sv */
// Types shared by the external pin interrupt latch
package epil_pkg;

   // ****************************************************************
   // Request latch states
   // ****************************************************************
   typedef enum logic [2:0] {
      epil_st_idle = 3'b001,
      epil_st_pend = 3'b010,
      epil_st_ackd = 3'b100
   } epil_state_t;

endpackage : epil_pkg

/* hw/epil_sync.sv */
// Pin synchroniser with falling edge detection
`timescale 1ns/1ps
`include "epil_cfg.svh"

module epil_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_n,
   output logic      pin_lvl,
   output logic      pin_fall
);

   logic meta;
   logic prev;

   // ****************************************************************
   // Two stages; only the second stage is looked at
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta    <= `EPIL_PIN_IDLE;
         pin_lvl <= `EPIL_PIN_IDLE;
         prev    <= `EPIL_PIN_IDLE;
      end else begin
         meta    <= pin_n;
         pin_lvl <= meta;
         prev    <= pin_lvl;
      end
   end

   // Compare with the previous sample so every new edge re-arms the latch
   assign pin_fall = prev & ~pin_lvl;

endmodule : epil_sync

/* hw/epil_top.sv */
// External pin interrupt latch with AXI4-Lite register access
`timescale 1ns/1ps
`include "epil_cfg.svh"

module epil_top
   import epil_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ext_int_n,
   input  wire logic                    vector_fetch,
   input  wire logic                    ccr_int_mask,
   output logic                         ext_request_latch,
   output logic                         ext_int_req,
   output logic                         cpu_int_req,
   output logic                         irq,
   input  wire logic [`EPIL_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [`EPIL_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   logic                    pin_lvl;
   logic                    pin_fall;
   logic                    trigger_sensitivity_select;
   logic                    ext_mask_bit;
   logic [`EPIL_EV_W-1:0]   int_status;
   logic [`EPIL_EV_W-1:0]   int_mask;
   logic [`EPIL_EV_W-1:0]   ev_pulse;
   epil_state_t             state;
   epil_state_t             next_state;
   logic                    set_evt;
   logic                    clear_act;
   logic                    sw_latch_clear_bit;
   logic                    aw_held;
   logic                    w_held;
   logic [`EPIL_ADDR_W-1:0] aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    wr_fire;
   logic                    wr_ext_int_status_ctrl_reg;
   logic                    wr_stat;
   logic                    wr_mask;
   logic                    rd_fire;
   logic                    rd_hit;
   logic                    rd_ext_int_status_ctrl_reg;
   logic [31:0]             rd_mux;

   // ****************************************************************
   // Pin front end
   // ****************************************************************
   epil_sync u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pin_n    (ext_int_n),
      .pin_lvl  (pin_lvl),
      .pin_fall (pin_fall)
   );

   // ****************************************************************
   // Request latch
   // ****************************************************************
   assign set_evt   = pin_fall | (trigger_sensitivity_select & ~pin_lvl);
   assign clear_act = vector_fetch | sw_latch_clear_bit;

   // Acknowledged state remembers the clear while the pin is still low
   always_comb begin
      next_state = state;
      case (state)
         epil_st_idle: begin
            if (set_evt) begin
               next_state = epil_st_pend;
            end
         end
         epil_st_pend: begin
            if (clear_act) begin
               if (trigger_sensitivity_select && !pin_lvl) begin
                  next_state = epil_st_ackd;
               end else if (pin_fall) begin
                  next_state = epil_st_pend;                               // New edge wins
               end else begin
                  next_state = epil_st_idle;
               end
            end
         end
         epil_st_ackd: begin
            if (pin_lvl || !trigger_sensitivity_select) begin
               next_state = epil_st_idle;
            end
         end
         default: begin
            next_state = epil_st_idle;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= epil_st_idle;
      end else begin
         state <= next_state;
      end
   end

   assign ext_request_latch = (state != epil_st_idle);
   assign ext_int_req       = ext_request_latch & ~ext_mask_bit;
   assign cpu_int_req       = ext_int_req & ~ccr_int_mask;

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign wr_ext_int_status_ctrl_reg       = wr_fire && (aw_addr == `EPIL_ADDR_EXT_INT_STATUS_CTRL_REG) && w_strb[0];
   assign wr_stat       = wr_fire && (aw_addr == `EPIL_ADDR_INT_STAT) && w_strb[0];
   assign wr_mask       = wr_fire && (aw_addr == `EPIL_ADDR_INT_MASK) && w_strb[0];

   // Acknowledge is a pulse, never stored, so it always reads back zero
   assign sw_latch_clear_bit = wr_ext_int_status_ctrl_reg && w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_ACK];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'h0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'h1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'h0;
         w_data <= `EPIL_WORD_ZERO;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'h1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp  <= `EPIL_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'h1;
         if (aw_addr == `EPIL_ADDR_EXT_INT_STATUS_CTRL_REG || aw_addr == `EPIL_ADDR_INT_STAT ||
             aw_addr == `EPIL_ADDR_INT_MASK) begin
            s_axi_bresp <= `EPIL_RESP_OKAY;
         end else begin
            s_axi_bresp <= `EPIL_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'h0;
      end
   end

   // ****************************************************************
   // Control bits
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trigger_sensitivity_select <= `EPIL_MODE_RST;
         ext_mask_bit               <= `EPIL_MASK_RST;
      end else if (wr_ext_int_status_ctrl_reg) begin
         trigger_sensitivity_select <= w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_MODE];
         ext_mask_bit               <= w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_MASK];
      end
   end

   // ****************************************************************
   // Interrupt status, mask and output
   // ****************************************************************
   assign ev_pulse[`EPIL_EV_SET] = (state == epil_st_idle) && (next_state != epil_st_idle);
   assign ev_pulse[`EPIL_EV_CLR] = (state != epil_st_idle) && (next_state == epil_st_idle);

   // A new event in the clearing cycle survives: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_status <= `EPIL_EV_RST;
      end else if (wr_stat) begin
         int_status <= (int_status & ~w_data[`EPIL_EV_W-1:0]) | ev_pulse;
      end else begin
         int_status <= int_status | ev_pulse;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_mask <= `EPIL_EV_RST;
      end else if (wr_mask) begin
         int_mask <= w_data[`EPIL_EV_W-1:0];
      end
   end

   assign irq = |(int_status & int_mask);

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_mux  = `EPIL_WORD_ZERO;
      rd_hit  = 1'h1;
      rd_ext_int_status_ctrl_reg = 1'h0;
      case (s_axi_araddr)
         `EPIL_ADDR_EXT_INT_STATUS_CTRL_REG: begin
            rd_ext_int_status_ctrl_reg                    = 1'h1;
            rd_mux[`EPIL_EXT_INT_STATUS_CTRL_REG_MODE]    = trigger_sensitivity_select;
            rd_mux[`EPIL_EXT_INT_STATUS_CTRL_REG_MASK]    = ext_mask_bit;
            rd_mux[`EPIL_EXT_INT_STATUS_CTRL_REG_FLAG]    = ext_request_latch;
            rd_mux[`EPIL_EXT_INT_STATUS_CTRL_REG_PIN]     = pin_lvl;
         end
         `EPIL_ADDR_INT_STAT: begin
            rd_mux[`EPIL_EV_W-1:0]     = int_status;
         end
         `EPIL_ADDR_INT_MASK: begin
            rd_mux[`EPIL_EV_W-1:0]     = int_mask;
         end
         default: begin
            rd_hit = 1'h0;
         end
      endcase
   end

   logic rd_was_ext_int_status_ctrl_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'h0;
         s_axi_rdata  <= `EPIL_WORD_ZERO;
         s_axi_rresp  <= `EPIL_RESP_OKAY;
         rd_was_ext_int_status_ctrl_reg  <= 1'h0;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'h1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? `EPIL_RESP_OKAY : `EPIL_RESP_SLVERR;
         rd_was_ext_int_status_ctrl_reg  <= rd_ext_int_status_ctrl_reg;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'h0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_FALL_SETS: assert property (
      pin_fall |=> ext_request_latch)
      else $error("Falling edge did not set the request latch");

   AST_EDGE_CLEAR: assert property (
      ext_request_latch && !trigger_sensitivity_select && clear_act && !pin_fall
      |=> !ext_request_latch)
      else $error("Clear action did not clear latch in edge mode");

   AST_SW_ACK: assert property (
      wr_ext_int_status_ctrl_reg && w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_ACK] && !trigger_sensitivity_select && !pin_fall
      |=> !ext_request_latch)
      else $error("Software acknowledge did not clear latch");

   AST_RESET_CLEARS: assert property (
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> !ext_request_latch && !ext_mask_bit && !trigger_sensitivity_select)
      else $error("Reset did not clear latch and control bits");

   AST_EDGE_HOLD: assert property (
      ext_request_latch && !trigger_sensitivity_select && !clear_act
      |=> ext_request_latch)
      else $error("Latch dropped in edge mode without clear action");

   AST_LEVEL_LOW_PENDING: assert property (
      trigger_sensitivity_select && !pin_lvl |=> ext_request_latch)
      else $error("Low level did not keep request pending");

   AST_LEVEL_ORDER: assert property (
      (state == epil_st_ackd) && trigger_sensitivity_select && pin_lvl
      |=> !ext_request_latch)
      else $error("Pin return after clear did not release latch");

   AST_LEVEL_NEEDS_CLEAR: assert property (
      ext_request_latch && (state == epil_st_pend) && !clear_act
      |=> ext_request_latch)
      else $error("Latch cleared without a clear action");

   AST_MASK_GATE: assert property (
      ext_mask_bit |-> !ext_int_req && !cpu_int_req)
      else $error("Masked request reached priority logic");

   AST_GLOBAL_MASK: assert property (
      ext_int_req && ccr_int_mask |-> !cpu_int_req)
      else $error("Global mask did not block request");

   AST_ACK_READS_ZERO: assert property (
      s_axi_rvalid && rd_was_ext_int_status_ctrl_reg |-> !s_axi_rdata[`EPIL_EXT_INT_STATUS_CTRL_REG_ACK])
      else $error("Acknowledge bit read back non-zero");

   AST_MASK_WRITE: assert property (
      wr_ext_int_status_ctrl_reg |=> ext_mask_bit == $past(w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_MASK])
               && trigger_sensitivity_select == $past(w_data[`EPIL_EXT_INT_STATUS_CTRL_REG_MODE]))
      else $error("Control write did not update mask or mode");

   AST_FLAG_READ: assert property (
      rd_fire && rd_ext_int_status_ctrl_reg |=> s_axi_rdata[`EPIL_EXT_INT_STATUS_CTRL_REG_FLAG] == $past(ext_request_latch))
      else $error("Event flag does not show latch state");

endmodule : epil_top

/* verif/epil_src.sv */
// Behavioural external interrupt source driving the active-low pin
`timescale 1ns/1ps
`include "epil_cfg.svh"

module epil_src (
   input  wire logic aclk,
   output logic      pin_n
);

   // ****************************************************************
   // Pin driver
   // ****************************************************************
   // The pin starts at the idle level and stays there until the first drive
   initial begin
      pin_n = `EPIL_PIN_IDLE;
   end

   task automatic drive(input logic lvl);
      @(posedge aclk);
      pin_n <= lvl;
   endtask : drive

endmodule : epil_src

/* verif/external_pin_interrupt_latch_bench.sv */
// Self-checking bench for the external pin interrupt latch
`timescale 1ns/1ps
`include "epil_cfg.svh"

module external_pin_interrupt_latch_bench;

   // ****************************************************************
   // Signals and model state
   // ****************************************************************
   logic        aclk, aresetn, ext_int_n, vector_fetch, ccr_int_mask;
   logic        ext_request_latch, ext_int_req, cpu_int_req, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r, seed;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, exp_stat, exp_ext_mask_bit;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        exp_latch, exp_mask, exp_mode, exp_pin;
   int          n_errors, check_count, cycles;

   epil_src src (.aclk(aclk), .pin_n(ext_int_n));

   epil_top dut (
      .aclk(aclk), .aresetn(aresetn), .ext_int_n(ext_int_n),
      .vector_fetch(vector_fetch), .ccr_int_mask(ccr_int_mask),
      .ext_request_latch(ext_request_latch), .ext_int_req(ext_int_req),
      .cpu_int_req(cpu_int_req), .irq(irq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );

   always #12.5 aclk = ~aclk;

   // Ceiling well above the few hundred cycles the sequence needs
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         complete_run();
      end
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [31:0] ext_int_status_ctrl_reg();
      return {27'h000_0000, exp_pin, exp_latch, 1'b0, exp_mask, exp_mode};
   endfunction : ext_int_status_ctrl_reg

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count = check_count + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Latch moves also record the sticky set and clear events
   task automatic m_latch(input logic v);
      if (v && !exp_latch) exp_stat[0] = 1'b1;
      if (!v && exp_latch) exp_stat[1] = 1'b1;
      exp_latch = v;
   endtask : m_latch

   task automatic ok();
      logic rq;
      #1;
      rq = exp_latch & ~exp_mask;
      chk("ext_request_latch", exp_latch, ext_request_latch);
      chk("ext_int_req", rq, ext_int_req);
      chk("cpu_int_req", rq & ~ccr_int_mask, cpu_int_req);
      chk("irq", |(exp_stat & exp_ext_mask_bit), irq);
   endtask : ok

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask : rd

   task automatic pin(input logic l, input int n);
      src.drive(l);
      repeat (n) @(posedge aclk);
      exp_pin = l;
   endtask : pin

   task automatic vfetch();
      @(posedge aclk);
      vector_fetch <= 1'b1;
      @(posedge aclk);
      vector_fetch <= 1'b0;
      @(posedge aclk);
   endtask : vfetch

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn   <= 1'b1;
      exp_latch = 1'b0;
      exp_mask  = 1'b0;
      exp_mode  = 1'b0;
      exp_stat  = 2'h0;
      exp_ext_mask_bit = 2'h0;
   endtask : rst

   task automatic tdone(input string nm);
      $display("test %s finished, %0d mismatches so far", nm, n_errors);
   endtask : tdone

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      vector_fetch = 1'b0;
      ccr_int_mask = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      seed = 32'hc479_2ecf;
      exp_pin = 1'b1;
      rst();
      ok();
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      rd(`EPIL_ADDR_INT_STAT, 32'h0000_0000, `EPIL_RESP_OKAY);
      rd(`EPIL_ADDR_INT_MASK, 32'h0000_0000, `EPIL_RESP_OKAY);
      tdone("reset");
      pin(1'b0, 6);
      m_latch(1'b1);
      ok();
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      vfetch();
      m_latch(1'b0);
      ok();
      pin(1'b0, 6);
      ok();
      pin(1'b1, 4);
      pin(1'b0, 6);
      m_latch(1'b1);
      ok();
      pin(1'b1, 6);
      ok();
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0004, `EPIL_RESP_OKAY);
      m_latch(1'b0);
      ok();
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      rd(`EPIL_ADDR_INT_STAT, {30'h0, exp_stat}, `EPIL_RESP_OKAY);
      wr(`EPIL_ADDR_INT_STAT, 32'h0000_0003, `EPIL_RESP_OKAY);
      exp_stat = 2'h0;
      rd(`EPIL_ADDR_INT_STAT, 32'h0000_0000, `EPIL_RESP_OKAY);
      tdone("edge");
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0002, `EPIL_RESP_OKAY);
      exp_mask = 1'b1;
      pin(1'b0, 6);
      pin(1'b1, 2);
      m_latch(1'b1);
      ok();
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0000, `EPIL_RESP_OKAY);
      exp_mask = 1'b0;
      ok();
      @(posedge aclk);
      ccr_int_mask <= 1'b1;
      ok();
      @(posedge aclk);
      ccr_int_mask <= 1'b0;
      vfetch();
      m_latch(1'b0);
      ok();
      tdone("mask");
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0001, `EPIL_RESP_OKAY);
      exp_mode = 1'b1;
      pin(1'b0, 6);
      m_latch(1'b1);
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0005, `EPIL_RESP_OKAY);
      pin(1'b0, 4);
      ok();
      vfetch();
      ok();
      pin(1'b1, 6);
      m_latch(1'b0);
      ok();
      pin(1'b0, 6);
      m_latch(1'b1);
      pin(1'b1, 6);
      ok();
      vfetch();
      m_latch(1'b0);
      ok();
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0000, `EPIL_RESP_OKAY);
      exp_mode = 1'b0;
      tdone("level");
      wr(`EPIL_ADDR_INT_STAT, 32'h0000_0003, `EPIL_RESP_OKAY);
      exp_stat = 2'h0;
      wr(`EPIL_ADDR_INT_MASK, 32'h0000_0001, `EPIL_RESP_OKAY);
      exp_ext_mask_bit = 2'h1;
      pin(1'b0, 6);
      pin(1'b1, 2);
      m_latch(1'b1);
      ok();
      wr(`EPIL_ADDR_INT_STAT, 32'h0000_0001, `EPIL_RESP_OKAY);
      exp_stat[0] = 1'b0;
      ok();
      vfetch();
      m_latch(1'b0);
      ok();
      wr(`EPIL_ADDR_INT_MASK, 32'h0000_0002, `EPIL_RESP_OKAY);
      exp_ext_mask_bit = 2'h2;
      ok();
      wr(`EPIL_ADDR_INT_STAT, 32'h0000_0003, `EPIL_RESP_OKAY);
      exp_stat = 2'h0;
      ok();
      tdone("irq");
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr(`EPIL_ADDR_INT_MASK, r, `EPIL_RESP_OKAY);
         exp_ext_mask_bit = r[1:0];
         rd(`EPIL_ADDR_INT_MASK, {30'h0, exp_ext_mask_bit}, `EPIL_RESP_OKAY);
         pin(1'b0, int'(r[3:2]) + 1);
         pin(1'b1, 5);
         m_latch(1'b1);
         ok();
         vfetch();
         m_latch(1'b0);
         ok();
      end
      tdone("random");
      rd(8'h0C, 32'h0000_0000, `EPIL_RESP_SLVERR);
      wr(8'h10, 32'hffff_ffff, `EPIL_RESP_SLVERR);
      ok();
      // A write without the low byte lane enabled must leave the control bits alone
      @(posedge aclk);
      s_axi_wstrb <= 4'he;
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0003, `EPIL_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      ok();
      tdone("unmapped");
      wr(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, 32'h0000_0003, `EPIL_RESP_OKAY);
      {exp_mode, exp_mask} = 2'h3;
      pin(1'b0, 6);
      m_latch(1'b1);
      pin(1'b1, 2);
      rst();
      ok();
      rd(`EPIL_ADDR_EXT_INT_STATUS_CTRL_REG, ext_int_status_ctrl_reg(), `EPIL_RESP_OKAY);
      tdone("second reset");
      complete_run();
   end

endmodule : external_pin_interrupt_latch_bench
